// File: bench/oim_checker_asserts.sv
// Port assertions for the operand index modifier
`timescale 1ns/100ps
module oim_checker (
    input logic        mclk_in,
    input logic        sys_rst_in,
    input logic        instr_valid_in,
    input logic        instr_done_in,
    input logic [1:0]  instr_class_in,
    input logic [3:0]  inh_src_in,
    input logic [2:0]  page_pointer_in,
    input logic [3:0]  word_pointer_in,
    input logic        int_permit_out,
    input logic        prefix_exec_out,
    input logic        flags_hold_out,
    input logic        ptr_write_block_out,
    input logic [3:0]  src_code_out,
    input logic [3:0]  dst_code_out,
    input logic [6:0]  ram_addr_out,
    input logic [3:0]  rom_ptr_mid_out,
    input logic [15:0] dst_write_onehot_out,
    input logic [2:0]  prefix_count_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Interrupt hold from prefix to completion
    property p_pfx;
        prefix_exec_out |-> !int_permit_out;
    endproperty
    a_pfx: assert property (p_pfx) else $error("permit during prefix");
    property p_pend;
        instr_valid_in && prefix_exec_out |=> !int_permit_out;
    endproperty
    a_pend: assert property (p_pend) else $error("permit after prefix");
    property p_rel;
        instr_valid_in && instr_done_in && !prefix_exec_out |=> int_permit_out || prefix_exec_out;
    endproperty
    a_rel: assert property (p_rel) else $error("hold not released");
    // Prefix side effects and counting
    property p_hold;
        flags_hold_out == prefix_exec_out && ptr_write_block_out == prefix_exec_out;
    endproperty
    a_hold: assert property (p_hold) else $error("flag or pointer hold wrong");
    property p_cnt;
        instr_valid_in && prefix_exec_out && prefix_count_out != 3'h7
            |=> prefix_count_out == $past(prefix_count_out) + 3'h1;
    endproperty
    a_cnt: assert property (p_cnt) else $error("prefix count wrong");
    // Operand steering
    property p_one;
        instr_valid_in && !prefix_exec_out && !instr_class_in[1] |=> dst_write_onehot_out == 16'h0001 << dst_code_out;
    endproperty
    a_one: assert property (p_one) else $error("write strobe wrong");
    property p_plain;
        instr_valid_in && !prefix_exec_out && int_permit_out && !instr_class_in[1]
            |=> src_code_out == $past(inh_src_in) && ram_addr_out == {$past(page_pointer_in), $past(word_pointer_in)};
    endproperty
    a_plain: assert property (p_plain) else $error("plain operand wrong");
    property p_rom;
        instr_class_in != 2'h2 |=> $stable(rom_ptr_mid_out);
    endproperty
    a_rom: assert property (p_rom) else $error("rom pointer changed");
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the operand index modifier
`timescale 1ns/100ps
module tb_top;
    reg         mclk_in, sys_rst_in, instr_valid_in, instr_done_in, inh_rom_operand_in, variant_io2_in;
    reg         int_request_in;
    reg  [7:0]  instr_byte_in;
    reg  [1:0]  instr_class_in;
    reg  [2:0]  page_pointer_in;
    reg  [3:0]  inh_src_in, inh_dst_in, rom_data_in, rom_ptr_imm_in, accumulator_in, flag_register_in;
    reg  [3:0]  word_pointer_in, ram_data_in, input_port_zero_in, input_port_one_in, input_port_two_in;
    reg  [3:0]  bidir_port_zero_in, bidir_port_one_in, bidir_port_two_in, output_port_zero_in;
    reg  [3:0]  output_port_one_in, output_port_two_in, output_port_three_in;
    wire        int_permit_out, int_take_out, prefix_exec_out, flags_hold_out, ptr_write_block_out;
    wire        ram_indexed_out, prefix_overflow_out;
    wire [3:0]  src_code_out, dst_code_out, alu_a_out, alu_b_out, rom_ptr_mid_out;
    wire [6:0]  ram_addr_out;
    wire [15:0] dst_write_onehot_out;
    wire [2:0]  prefix_count_out;
    reg  [31:0] r;
    integer     failures, checked, i;
    // Rows: two prefixes, inherent src and dst, expected src and dst
    localparam [159:0] ROWS = 160'h9c8e12ec_00006767_a1a40212_87a21277_a5931253;
    // Source data per operand code, code f first
    localparam [63:0]  SEL = 64'hfedc029876054321;

    oim_operand_index_modifier i_dut (.*);

    // Compare one result
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // Present one byte after the falling edge
    task step(input v, input [7:0] b, input d);
        begin
            @(negedge mclk_in);
            instr_valid_in = v;
            instr_byte_in = b;
            instr_done_in = d;
            #1;
        end
    endtask

    // Completing instruction, then one idle cycle
    task proc;
        begin
            step(1'b1, 8'h2b, 1'b1);
            step(1'b0, 8'h00, 1'b0);
        end
    endtask

    // Counts, verdict and stop
    task end_sim;
        begin
            $display("checked=%0d failures=%0d", checked, failures);
            if (failures == 0 && checked > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask

    // Clock at 10 MHz
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    // Watchdog far past the expected run
    initial begin
        #200000;
        failures = failures + 1;
        end_sim;
    end

    // Main sequence
    initial begin
        failures = 0;
        checked = 0;
        {sys_rst_in, instr_valid_in, instr_done_in, inh_rom_operand_in, variant_io2_in, int_request_in} = 6'h21;
        instr_byte_in = 8'h00;
        instr_class_in = 2'h1;
        page_pointer_in = 3'h2;
        {inh_src_in, inh_dst_in, rom_data_in, rom_ptr_imm_in} = 16'h009a;
        {accumulator_in, flag_register_in, word_pointer_in, ram_data_in, input_port_zero_in, bidir_port_zero_in,
         bidir_port_one_in, output_port_one_in, output_port_zero_in, bidir_port_two_in, output_port_three_in,
         output_port_two_in, input_port_one_in, input_port_two_in} = 56'h123456789bcdef;
        repeat (4) @(negedge mclk_in);
        chk({src_code_out, dst_code_out, alu_a_out, alu_b_out}, 16'h0000);
        chk({ram_indexed_out, ram_addr_out, prefix_count_out, prefix_overflow_out}, 16'h0000);
        sys_rst_in = 1'b0;
        $display("reset test done");
        // Prefix combinations from the table
        for (i = 0; i < 5; i = i + 1) begin
            r = ROWS[i*32 +: 32];
            {inh_src_in, inh_dst_in} = r[15:8];
            step(r[31:24] != 8'h00, r[31:24], 1'b0);
            chk({int_permit_out, int_take_out}, {2{r[31:24] == 8'h00}});
            step(r[23:16] != 8'h00, r[23:16], 1'b0);
            proc;
            chk({src_code_out, dst_code_out}, r[7:0]);
            chk(dst_write_onehot_out, 16'h0001 << r[3:0]);
            chk({int_permit_out, int_take_out}, 2'b11);
            proc;
            chk({src_code_out, dst_code_out}, r[15:8]);
            $display("row %0d done", i);
        end
        // Every operand code as source, code c in both variants
        for (i = 0; i < 17; i = i + 1) begin
            variant_io2_in = (i == 16);
            inh_src_in = (i == 16) ? 4'hc : i[3:0];
            proc;
            chk(alu_a_out, (i == 16) ? 4'hb : SEL[i*4 +: 4]);
        end
        $display("operand select test done");
        // RAM prefix on a register and RAM instruction
        instr_class_in = 2'h0;
        inh_rom_operand_in = 1'b1;
        step(1'b1, 8'hb7, 1'b0);
        chk({flags_hold_out, ptr_write_block_out}, 2'b11);
        proc;
        chk({ram_indexed_out, ram_addr_out}, 8'h87);
        chk(alu_b_out, 4'h9);
        inh_rom_operand_in = 1'b0;
        proc;
        chk({ram_indexed_out, ram_addr_out, alu_b_out}, 12'h234);
        $display("ram prefix test done");
        // Source prefix on the ROM pointer set
        instr_class_in = 2'h2;
        step(1'b1, 8'ha0, 1'b0);
        proc;
        chk(rom_ptr_mid_out, 4'hb);
        $display("rom pointer test done");
        // Four prefixes, first designations kept
        instr_class_in = 2'h1;
        step(1'b1, 8'ha1, 1'b0);
        step(1'b1, 8'h92, 1'b0);
        step(1'b1, 8'h83, 1'b0);
        step(1'b1, 8'ha4, 1'b0);
        step(1'b0, 8'h00, 1'b0);
        step(1'b0, 8'h00, 1'b0);
        chk({prefix_overflow_out, prefix_count_out}, 4'hc);
        proc;
        chk({src_code_out, dst_code_out}, 8'h12);
        $display("prefix limit test done");
        // RAM prefix turns a redirected operand into page-zero RAM
        {inh_src_in, inh_dst_in} = 8'h12;
        step(1'b1, 8'ha6, 1'b0);
        step(1'b1, 8'hb9, 1'b0);
        proc;
        chk({src_code_out, dst_code_out}, 8'h32);
        chk({ram_indexed_out, ram_addr_out}, 8'h89);
        // RAM prefix on the ROM pointer set
        instr_class_in = 2'h2;
        step(1'b1, 8'hb5, 1'b0);
        proc;
        chk(rom_ptr_mid_out, 4'h4);
        instr_class_in = 2'h1;
        $display("ram index test done");
        // Mid-run reset drops a pending prefix
        step(1'b1, 8'ha5, 1'b0);
        step(1'b0, 8'h00, 1'b0);
        sys_rst_in = 1'b1;
        step(1'b0, 8'h00, 1'b0);
        sys_rst_in = 1'b0;
        chk({int_permit_out, int_take_out, prefix_count_out}, 5'h18);
        proc;
        chk({src_code_out, dst_code_out}, 8'h12);
        $display("mid-run reset test done");
        end_sim;
    end
endmodule

// Attach the port checker to the block
bind oim_operand_index_modifier oim_checker i_chk (.*);

// File: verilog/oim_defines.vh
// Operand index modifier constants: opcodes, operand codes, instruction class codes
`ifndef OIM_DEFINES_VH
`define OIM_DEFINES_VH

// Prefix opcodes, upper nibble of the instruction byte
`define OIM_OP_DUAL        4'h8
`define OIM_OP_DEST        4'h9
`define OIM_OP_SRC         4'ha
`define OIM_OP_RAM         4'hb

// Operand codes selecting a register or port
`define OIM_R_ACC          4'h0
`define OIM_R_FLAG         4'h1
`define OIM_R_WORDP        4'h2
`define OIM_R_RAM          4'h3
`define OIM_R_IN0          4'h4
`define OIM_R_NULL         4'h5
`define OIM_R_IO0          4'h6
`define OIM_R_IO1          4'h7
`define OIM_R_OT1          4'h8
`define OIM_R_OT0          4'h9
`define OIM_R_PAGEP        4'ha
`define OIM_R_UNUSED       4'hb
`define OIM_R_OT3_IO2      4'hc
`define OIM_R_OT2          4'hd
`define OIM_R_IN1          4'he
`define OIM_R_IN2          4'hf

// Instruction class codes supplied by the decoder
`define OIM_CLS_REGRAM     2'h0
`define OIM_CLS_REGONLY    2'h1
`define OIM_CLS_ROMPTR     2'h2
`define OIM_CLS_OTHER      2'h3

// Reset value of every index latch
`define OIM_LATCH_RST      4'h0

// Prefix execution time, one machine cycle
`define OIM_PREFIX_CYCLES  1

`endif

// File: verilog/oim_index_latch.v
// One first-write-wins 4-bit index latch with its written flag
`timescale 1ns/100ps
`include "oim_defines.vh"

module oim_index_latch (
    input  wire       mclk_in,
    input  wire       sys_rst_in,
    input  wire       load_in,
    input  wire [3:0] code_in,
    input  wire       clear_in,
    output reg  [3:0] code_out,
    output reg        valid_out
);

    // First load sets the flag; later loads are ignored until clear
    always @(posedge mclk_in) begin
        if (sys_rst_in || clear_in) begin
            code_out  <= `OIM_LATCH_RST;
            valid_out <= 1'b0;
        end else if (load_in && !valid_out) begin
            code_out  <= code_in;
            valid_out <= 1'b1;
        end
    end

endmodule

// File: verilog/oim_mux16.v
// Sixteen-way 4-bit operand selector indexed by operand code
`timescale 1ns/100ps

module oim_mux16 (
    input  wire [3:0]  sel_in,
    input  wire [63:0] data_in,
    output wire [3:0]  data_out
);

    // Pick one nibble of the flattened bank
    assign data_out = data_in[{sel_in, 2'b00} +: 4];

endmodule

// File: verilog/oim_operand_index_modifier.v
// Operand index modifier: prefix latches, operand selectors, interrupt hold
`timescale 1ns/100ps
`include "oim_defines.vh"

module oim_operand_index_modifier (
    input  wire       mclk_in,
    input  wire       sys_rst_in,
    // Instruction fetch side
    input  wire       instr_valid_in,
    input  wire [7:0] instr_byte_in,
    input  wire [1:0] instr_class_in,
    input  wire [3:0] inh_src_in,
    input  wire [3:0] inh_dst_in,
    input  wire       inh_rom_operand_in,
    input  wire       instr_done_in,
    input  wire       variant_io2_in,
    // Pointer registers and operand data
    input  wire [2:0] page_pointer_in,
    input  wire [3:0] word_pointer_in,
    input  wire [3:0] accumulator_in,
    input  wire [3:0] flag_register_in,
    input  wire [3:0] ram_data_in,
    input  wire [3:0] rom_data_in,
    input  wire [3:0] input_port_zero_in,
    input  wire [3:0] input_port_one_in,
    input  wire [3:0] input_port_two_in,
    input  wire [3:0] bidir_port_zero_in,
    input  wire [3:0] bidir_port_one_in,
    input  wire [3:0] bidir_port_two_in,
    input  wire [3:0] output_port_zero_in,
    input  wire [3:0] output_port_one_in,
    input  wire [3:0] output_port_two_in,
    input  wire [3:0] output_port_three_in,
    input  wire [3:0] rom_ptr_imm_in,
    // Interrupt controller side
    input  wire       int_request_in,
    output wire       int_permit_out,
    output wire       int_take_out,
    // Decoded operand steering
    output wire       prefix_exec_out,
    output wire       flags_hold_out,
    output wire       ptr_write_block_out,
    output reg  [3:0] src_code_out,
    output reg  [3:0] dst_code_out,
    output reg  [3:0] alu_a_out,
    output reg  [3:0] alu_b_out,
    output reg  [6:0] ram_addr_out,
    output reg        ram_indexed_out,
    output reg  [3:0] rom_ptr_mid_out,
    output reg  [15:0] dst_write_onehot_out,
    output reg  [2:0] prefix_count_out,
    output reg        prefix_overflow_out
);

    // Opcode decode of the current byte
    wire [3:0] op_hi;
    wire [3:0] op_lo;
    wire       is_dual;
    wire       is_dest;
    wire       is_src;
    wire       is_ram;
    wire       is_prefix;

    assign op_hi     = instr_byte_in[7:4];
    assign op_lo     = instr_byte_in[3:0];
    assign is_dual   = instr_valid_in && (op_hi == `OIM_OP_DUAL);
    assign is_dest   = instr_valid_in && (op_hi == `OIM_OP_DEST);
    assign is_src    = instr_valid_in && (op_hi == `OIM_OP_SRC);
    assign is_ram    = instr_valid_in && (op_hi == `OIM_OP_RAM);
    assign is_prefix = is_dual || is_dest || is_src || is_ram;

    // Prefixes are single-cycle and never touch branch/carry or pointers
    assign prefix_exec_out     = is_prefix;
    assign flags_hold_out      = is_prefix;
    assign ptr_write_block_out = is_prefix;

    // Latch outputs
    wire [3:0] sa_code;
    wire [3:0] da_code;
    wire [3:0] ma_code;
    wire       sa_valid;
    wire       da_valid;
    wire       ma_valid;
    wire       clear_all;

    // Clear when the modified processing instruction completes
    assign clear_all = instr_done_in && !is_prefix;

    oim_index_latch u_source_index_latch (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .load_in    (is_src || is_dual),
        .code_in    (op_lo),
        .clear_in   (clear_all),
        .code_out   (sa_code),
        .valid_out  (sa_valid)
    );

    oim_index_latch u_dest_index_latch (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .load_in    (is_dest || is_dual),
        .code_in    (op_lo),
        .clear_in   (clear_all),
        .code_out   (da_code),
        .valid_out  (da_valid)
    );

    oim_index_latch u_ram_index_latch (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .load_in    (is_ram),
        .code_in    (op_lo),
        .clear_in   (clear_all),
        .code_out   (ma_code),
        .valid_out  (ma_valid)
    );

    // Pending-prefix state holds off interrupts
    reg pending_q;
    reg pending_d;

    always @* begin
        pending_d = pending_q;
        if (is_prefix) begin
            pending_d = 1'b1;
        end else if (clear_all) begin
            pending_d = 1'b0;
        end
    end

    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= pending_d;
        end
    end

    // Interrupt permitted only with no prefix in flight
    assign int_permit_out = !pending_q && !is_prefix;
    assign int_take_out   = int_request_in && int_permit_out;

    // Prefix counter flags code with more than three prefixes
    reg [2:0] count_q;
    reg [2:0] count_d;

    always @* begin
        count_d = count_q;
        if (is_prefix) begin
            if (count_q != 3'h7) begin
                count_d = count_q + 3'h1;
            end
        end else if (clear_all) begin
            count_d = 3'h0;
        end
    end

    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            count_q <= 3'h0;
        end else begin
            count_q <= count_d;
        end
    end

    // Registered status of the prefix chain
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            prefix_count_out    <= 3'h0;
            prefix_overflow_out <= 1'b0;
        end else begin
            prefix_count_out    <= count_d;
            prefix_overflow_out <= (count_d > 3'h3);
        end
    end

    // Effective operand codes, falling back to inherent ones
    reg [3:0] src_eff;
    reg [3:0] dst_eff;
    reg       src_is_ram;
    reg       dst_is_ram;

    always @* begin
        src_eff = sa_valid ? sa_code : inh_src_in;
        dst_eff = da_valid ? da_code : inh_dst_in;
        src_is_ram = (src_eff == `OIM_R_RAM);
        dst_is_ram = (dst_eff == `OIM_R_RAM);
        case (instr_class_in)
            `OIM_CLS_REGRAM: begin
                // Redirection by source/destination; RAM prefix moves RAM
                src_is_ram = (src_eff == `OIM_R_RAM);
                dst_is_ram = (dst_eff == `OIM_R_RAM);
            end
            `OIM_CLS_REGONLY: begin
                // RAM prefix turns the redirected operand into RAM
                if (ma_valid && sa_valid) begin
                    src_eff = `OIM_R_RAM;
                end
                if (ma_valid && da_valid) begin
                    dst_eff = `OIM_R_RAM;
                end
                src_is_ram = (src_eff == `OIM_R_RAM);
                dst_is_ram = (dst_eff == `OIM_R_RAM);
            end
            default: begin
                src_is_ram = (src_eff == `OIM_R_RAM);
                dst_is_ram = (dst_eff == `OIM_R_RAM);
            end
        endcase
    end

    // Operand bank ordered by operand code
    wire [63:0] bank;
    wire [3:0]  code_c_data;
    wire [3:0]  src_data;

    // Slots for codes 0 to 7
    wire [3:0]  slot_0;
    wire [3:0]  slot_1;
    wire [3:0]  slot_2;
    wire [3:0]  slot_3;
    wire [3:0]  slot_4;
    wire [3:0]  slot_5;
    wire [3:0]  slot_6;
    wire [3:0]  slot_7;

    // Slots for codes 8 to f
    wire [3:0]  slot_8;
    wire [3:0]  slot_9;
    wire [3:0]  slot_a;
    wire [3:0]  slot_b;
    wire [3:0]  slot_c;
    wire [3:0]  slot_d;
    wire [3:0]  slot_e;
    wire [3:0]  slot_f;

    // Code c follows the port variant
    assign code_c_data = variant_io2_in ? bidir_port_two_in : output_port_three_in;

    // Registers and ports for codes 0 to 7; code 5 reads zero
    assign slot_0 = accumulator_in;
    assign slot_1 = flag_register_in;
    assign slot_2 = word_pointer_in;
    assign slot_3 = ram_data_in;
    assign slot_4 = input_port_zero_in;
    assign slot_5 = 4'h0;
    assign slot_6 = bidir_port_zero_in;
    assign slot_7 = bidir_port_one_in;

    // Ports and page pointer for codes 8 to f; code b reads zero
    assign slot_8 = output_port_one_in;
    assign slot_9 = output_port_zero_in;
    assign slot_a = {1'b0, page_pointer_in};
    assign slot_b = 4'h0;
    assign slot_c = code_c_data;
    assign slot_d = output_port_two_in;
    assign slot_e = input_port_one_in;
    assign slot_f = input_port_two_in;

    // Flattened bank, code f in the top nibble
    assign bank = {slot_f, slot_e, slot_d, slot_c, slot_b, slot_a, slot_9, slot_8,
                   slot_7, slot_6, slot_5, slot_4, slot_3, slot_2, slot_1, slot_0};

    oim_mux16 u_source_selector (
        .sel_in   (src_eff),
        .data_in  (bank),
        .data_out (src_data)
    );

    // Single RAM address for source and destination
    reg [6:0] ram_addr_d;
    reg       indexed_d;

    always @* begin
        indexed_d  = ma_valid;
        ram_addr_d = {page_pointer_in, word_pointer_in};
        if (ma_valid) begin
            ram_addr_d = {3'h0, ma_code};
        end
    end

    // Registered steering outputs
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            src_code_out         <= `OIM_R_ACC;
            dst_code_out         <= `OIM_R_ACC;
            alu_a_out            <= 4'h0;
            alu_b_out            <= 4'h0;
            ram_addr_out         <= 7'h00;
            ram_indexed_out      <= 1'b0;
        end else begin
            src_code_out    <= src_eff;
            dst_code_out    <= dst_eff;
            alu_a_out       <= src_data;
            alu_b_out       <= inh_rom_operand_in ? rom_data_in : ram_data_in;
            ram_addr_out    <= ram_addr_d;
            ram_indexed_out <= indexed_d;
        end
    end

    // ROM pointer middle nibble, refreshed only by the pointer-set class
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rom_ptr_mid_out <= 4'h0;
        end else if (instr_class_in == `OIM_CLS_ROMPTR) begin
            if (ma_valid) begin
                rom_ptr_mid_out <= ram_data_in;
            end else if (sa_valid) begin
                rom_ptr_mid_out <= src_data | rom_ptr_imm_in;
            end else begin
                rom_ptr_mid_out <= rom_ptr_imm_in;
            end
        end
    end

    // Destination write strobe for each non-prefix instruction
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            dst_write_onehot_out <= 16'h0000;
        end else if (instr_valid_in && !is_prefix) begin
            dst_write_onehot_out <= 16'h0001 << dst_eff;
        end else begin
            dst_write_onehot_out <= 16'h0000;
        end
    end

endmodule
